// *** rtl/eec_exception_entry_control.sv ***
// module: exception entry control, picks and launches reset, trap and interrupt exceptions
`timescale 1ns/1ps
// ----------------------------------------------------------------------------
// ----------------------------------------------------------------------------
module eec_exception_entry_control #(
  parameter int N_IRQ = eec_pkg::IRQ_W
) (
  input wire logic CLOCK,
  input wire logic RESET_N,
  input wire logic CLK_EN,
  input wire logic EXTERNAL_RESET_INPUT_N,
  input wire logic WDT_OVERFLOW,
  input wire logic SOFTWARE_TRAP_OPCODE,
  input wire logic [1:0] TRAP_NUMBER,
  input wire logic NMI_REQ,
  input wire logic BREAK_REQ,
  input wire logic [N_IRQ-1:0] IRQ_REQ,
  input wire logic INSN_BOUNDARY,
  input wire logic ENTRY_DONE,
  input wire logic MASK_CLEAR,
  input wire logic MASK_SET,
  output logic CHIP_RESET,
  output logic EXC_START,
  output logic [eec_pkg::VEC_W-1:0] EXC_VECTOR,
  output logic [eec_pkg::ADDR_W-1:0] EXC_VEC_ADDR,
  output logic EXC_BUSY,
  output logic INT_MASK
);
  import eec_pkg::*;

  function automatic logic [ADDR_W-1:0] vec_addr(input logic [VEC_W-1:0] v);
    vec_addr = VEC_TABLE_BASE + (ADDR_W'(v) << VEC_ENTRY_SHIFT);
  endfunction

  eec_state_t state_q;
  logic in_reset;
  logic irq_any;
  logic [VEC_W-1:0] irq_vec;
  logic [N_IRQ-1:0] irq_gated;
  logic boundary;
  logic int_take;
  logic [VEC_W-1:0] int_vec;

  // ----------------------------------------------------------------------------
  // request selection
  // ----------------------------------------------------------------------------
  assign in_reset = !EXTERNAL_RESET_INPUT_N || WDT_OVERFLOW;
  assign irq_gated = INT_MASK ? '0 : IRQ_REQ;

  eec_vec_enc #(.N(N_IRQ)) u_enc (
    .req(irq_gated),
    .any(irq_any),
    .vec(irq_vec)
  );

  assign boundary = (state_q == EEC_RUN && INSN_BOUNDARY) || (state_q == EEC_ENTRY && ENTRY_DONE);
  assign int_take = boundary && (NMI_REQ || BREAK_REQ || irq_any) && !SOFTWARE_TRAP_OPCODE;

  // the if chain gives priority: nmi, then break, then the maskable ones
  always_comb begin
    if (NMI_REQ) begin
      int_vec = VEC_NMI;
    end else if (BREAK_REQ) begin
      int_vec = VEC_BREAK;
    end else begin
      int_vec = irq_vec;
    end
  end

  // ----------------------------------------------------------------------------
  // sequencer
  // ----------------------------------------------------------------------------
  always_ff @(posedge CLOCK) begin
    if (!RESET_N) begin
      state_q <= EEC_HOLD;
    end else if (CLK_EN) begin
      case (state_q)
        EEC_HOLD: begin
          if (!in_reset) begin
            state_q <= EEC_ENTRY;
          end
        end
        // a trap seen in ENTRY is dropped: the core never decodes one mid-entry
        EEC_RUN, EEC_ENTRY: begin
          if (in_reset) begin
            state_q <= EEC_HOLD;
          end else if ((state_q == EEC_RUN && SOFTWARE_TRAP_OPCODE) || int_take) begin
            state_q <= EEC_ENTRY;
          end else if (state_q == EEC_ENTRY && ENTRY_DONE) begin
            state_q <= EEC_RUN;
          end
        end
        default: state_q <= EEC_HOLD;
      endcase
    end
  end

  always_ff @(posedge CLOCK) begin
    if (!RESET_N) begin
      EXC_START <= 1'b0;
      EXC_VECTOR <= VEC_RESET;
      EXC_VEC_ADDR <= VEC_TABLE_BASE;
    end else if (CLK_EN) begin
      EXC_START <= 1'b0;
      if (state_q == EEC_HOLD) begin
        if (!in_reset) begin
          EXC_START <= 1'b1;
          EXC_VECTOR <= VEC_RESET;
          EXC_VEC_ADDR <= vec_addr(VEC_RESET);
        end
      end else if (in_reset) begin
        EXC_START <= 1'b0;
      end else if (state_q == EEC_RUN && SOFTWARE_TRAP_OPCODE) begin
        EXC_START <= 1'b1;
        EXC_VECTOR <= VEC_TRAP0 + VEC_W'(TRAP_NUMBER);
        EXC_VEC_ADDR <= vec_addr(VEC_TRAP0 + VEC_W'(TRAP_NUMBER));
      end else if (int_take) begin
        EXC_START <= 1'b1;
        EXC_VECTOR <= int_vec;
        EXC_VEC_ADDR <= vec_addr(int_vec);
      end
    end
  end

  always_ff @(posedge CLOCK) begin
    if (!RESET_N) begin
      CHIP_RESET <= 1'b1;
      EXC_BUSY <= 1'b0;
    end else if (CLK_EN) begin
      CHIP_RESET <= in_reset;
      // busy rises with the start pulse and drops on the edge that takes the done pulse
      EXC_BUSY <= (state_q == EEC_HOLD) ? !in_reset : (!in_reset && (state_q == EEC_ENTRY ? !ENTRY_DONE || int_take
                  : SOFTWARE_TRAP_OPCODE || int_take));
    end
  end

  // mask bit: hardware set on any entry wins over a software clear
  always_ff @(posedge CLOCK) begin
    if (!RESET_N) begin
      INT_MASK <= 1'b1;
    end else if (CLK_EN) begin
      if (state_q == EEC_HOLD || in_reset) begin
        INT_MASK <= 1'b1;
      end else if ((state_q == EEC_RUN && SOFTWARE_TRAP_OPCODE) || int_take || MASK_SET) begin
        INT_MASK <= 1'b1;
      end else if (MASK_CLEAR) begin
        INT_MASK <= 1'b0;
      end
    end
  end

  // ----------------------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------------------
  default clocking cb @(posedge CLOCK); endclocking
  default disable iff (!RESET_N);

  a_reset_wait_release: assert property (CLK_EN && in_reset |=> !EXC_START)
    else $error("exception started while reset held");
  a_reset_first: assert property (CLK_EN && state_q == EEC_HOLD && !in_reset |=> EXC_START && EXC_VECTOR == 8'h00)
    else $error("reset entry not launched after release");
  a_wdt_chip_reset: assert property (CLK_EN && WDT_OVERFLOW |=> CHIP_RESET && state_q == EEC_HOLD)
    else $error("watchdog overflow did not reset");
  a_trap_vector: assert property (CLK_EN && state_q == EEC_RUN && !in_reset && SOFTWARE_TRAP_OPCODE
    |=> EXC_START && EXC_VECTOR == 8'h08 + $past(TRAP_NUMBER))
    else $error("trap vector wrong");
  a_trap_ignores_mask: assert property (CLK_EN && INT_MASK && state_q == EEC_RUN && !in_reset && SOFTWARE_TRAP_OPCODE
    |=> EXC_START)
    else $error("trap blocked by mask");
  a_mask_blocks: assert property (CLK_EN && INT_MASK && !NMI_REQ && !BREAK_REQ && !SOFTWARE_TRAP_OPCODE
    && state_q != EEC_HOLD |=> !EXC_START)
    else $error("masked interrupt taken");
  a_int_boundary: assert property (CLK_EN && state_q == EEC_RUN && !INSN_BOUNDARY && !SOFTWARE_TRAP_OPCODE
    |=> !EXC_START)
    else $error("interrupt taken off boundary");
  a_nmi_priority: assert property (CLK_EN && int_take && !in_reset && NMI_REQ |=> EXC_VECTOR == 8'h07)
    else $error("nmi not highest interrupt");
  a_vec_addr: assert property (EXC_START |-> EXC_VEC_ADDR == {7'h00, EXC_VECTOR, 1'b0})
    else $error("vector address mismatch");
  a_reset_mask: assert property (CLK_EN && state_q == EEC_HOLD |=> INT_MASK)
    else $error("mask not set at reset entry");

  // unmaskable break and the lowest maskable line, each checked against its fixed vector
  a_break_unmasked: assert property (CLK_EN && state_q == EEC_RUN && INSN_BOUNDARY && !in_reset
    && !SOFTWARE_TRAP_OPCODE && !NMI_REQ && BREAK_REQ |=> EXC_START && EXC_VECTOR == VEC_BREAK)
    else $error("break request not taken");
  a_irq_lowest: assert property (CLK_EN && int_take && !in_reset && !NMI_REQ && !BREAK_REQ && IRQ_REQ[0]
    |=> EXC_VECTOR == VEC_IRQ_BASE)
    else $error("lowest maskable line not served first");
  a_chip_reset: assert property (CLK_EN && in_reset |=> CHIP_RESET && !EXC_BUSY)
    else $error("chip reset not raised");
  a_mask_sw_set: assert property (CLK_EN && state_q != EEC_HOLD && !in_reset && MASK_SET |=> INT_MASK)
    else $error("software set of mask lost");
  a_busy_start: assert property (EXC_START |-> EXC_BUSY)
    else $error("start without busy");
  // a frozen clock enable must hold the sequencer state, the mask bit and the vector
  a_enable_freeze: assert property (!CLK_EN |=> $stable(state_q) && $stable(INT_MASK) && $stable(EXC_VECTOR))
    else $error("state moved while clock enable low");

  // ----------------------------------------------------------------------------
  // coverage of the main scenarios
  // ----------------------------------------------------------------------------

  c_reset_entry: cover property (EXC_START && EXC_VECTOR == 8'h00);
  c_trap3: cover property (EXC_START && EXC_VECTOR == 8'h0B);
  c_nmi: cover property (EXC_START && EXC_VECTOR == 8'h07);
  c_irq: cover property (EXC_START && EXC_VECTOR > 8'h0D);
  c_break: cover property (EXC_START && EXC_VECTOR == VEC_BREAK);
endmodule // eec_exception_entry_control

// *** rtl/eec_pkg.sv ***
// package: constants and types for the exception entry control block
package eec_pkg;
  localparam int VEC_W = 8;
  localparam int ADDR_W = 16;
  localparam int IRQ_W = 26;
  localparam logic [VEC_W-1:0] VEC_RESET = 8'h00;
  localparam logic [VEC_W-1:0] VEC_NMI = 8'h07;
  localparam logic [VEC_W-1:0] VEC_TRAP0 = 8'h08;
  localparam logic [VEC_W-1:0] VEC_BREAK = 8'h0C;
  localparam logic [VEC_W-1:0] VEC_IRQ_BASE = 8'h0E;
  localparam logic [ADDR_W-1:0] VEC_TABLE_BASE = 16'h0000;
  localparam int VEC_ENTRY_SHIFT = 1;
  typedef enum logic [1:0] {EEC_RUN, EEC_HOLD, EEC_ENTRY} eec_state_t;
endpackage

// *** rtl/eec_vec_enc.sv ***
// module: priority encoder for maskable interrupt requests
`timescale 1ns/1ps
module eec_vec_enc #(
  parameter int N = eec_pkg::IRQ_W
) (
  input wire logic [N-1:0] req,
  output logic any,
  output logic [eec_pkg::VEC_W-1:0] vec
);
  import eec_pkg::*;
  // lowest index wins, index 0 maps to the lowest maskable vector
  always_comb begin
    any = 1'b0;
    vec = VEC_IRQ_BASE;
    for (int i = N - 1; i >= 0; i--) begin
      if (req[i]) begin
        any = 1'b1;
        vec = VEC_IRQ_BASE + VEC_W'(i);
      end
    end
  end
endmodule // eec_vec_enc

// *** sim/eec_core_model.sv ***
// core sequencer model: answers each exception start with a done pulse
`timescale 1ns/1ps
// ----------------------------------------
// done pulse after a chosen number of cycles
// ----------------------------------------
module eec_core_model (
  input wire logic clk,
  input wire logic exc_start,
  input wire logic [2:0] lat,
  output logic entry_done
);
  initial entry_done = 1'b0;
  always @(posedge clk) begin
    if (exc_start === 1'b1) begin
      repeat (lat) @(posedge clk);
      #1 entry_done = 1'b1;
      @(posedge clk);
      #1 entry_done = 1'b0;
    end
  end
endmodule // eec_core_model

// *** sim/eec_exception_entry_control_tb_top.sv ***
// testbench: exception entry control against a reference model
`timescale 1ns/1ps
module eec_exception_entry_control_tb_top;
  import eec_pkg::*;
  logic clk = 1'b0, rst_n = 1'b0, ext_n = 1'b0, wdt = 1'b0, trap = 1'b0, nmi = 1'b0;
  logic brk = 1'b0, bnd = 1'b0, mclr = 1'b0, done, chip_rst, start, busy, imask;
  logic en = 1'b1, mset = 1'b0;
  logic [1:0] tn = 2'h0;
  logic [25:0] irq = 26'h0;
  logic [2:0] lat = 3'h1;
  logic [7:0] vec;
  logic [15:0] vaddr;
  logic [15:0] lfsr = 16'h0050;
  int num_errors = 0, n_checks = 0, e;
  // ----------------------------------------
  // clock, design and core model
  // ----------------------------------------
  always #25 clk = ~clk;
  eec_exception_entry_control DUT (.CLOCK(clk), .RESET_N(rst_n), .CLK_EN(en),
    .EXTERNAL_RESET_INPUT_N(ext_n), .WDT_OVERFLOW(wdt), .SOFTWARE_TRAP_OPCODE(trap), .TRAP_NUMBER(tn),
    .NMI_REQ(nmi), .BREAK_REQ(brk), .IRQ_REQ(irq), .INSN_BOUNDARY(bnd), .ENTRY_DONE(done),
    .MASK_CLEAR(mclr), .MASK_SET(mset), .CHIP_RESET(chip_rst), .EXC_START(start), .EXC_VECTOR(vec),
    .EXC_VEC_ADDR(vaddr), .EXC_BUSY(busy), .INT_MASK(imask));
  eec_core_model core (.clk(clk), .exc_start(start), .lat(lat), .entry_done(done));
  // ----------------------------------------
  // model, checks and bus steps
  // ----------------------------------------
  function automatic int ref_vec(logic t, logic [1:0] n, logic m, logic b, logic [25:0] q, logic mask);
    if (t) return 8 + n;
    if (m) return 7;
    if (b) return 12;
    for (int i = 0; i < 26; i++) if (!mask && q[i]) return 14 + i;
    return -1;
  endfunction
  task automatic check(logic [15:0] seen, logic [15:0] exp, string what);
    n_checks++;
    if (seen !== exp) begin
      num_errors++;
      $display("[FAIL] %0t %s seen %h expected %h", $time, what, seen, exp);
    end
  endtask
  task automatic fire(int x);
    int k;
    @(posedge clk);
    #1;
    trap = 0; bnd = 0; nmi = 0; brk = 0; irq = '0;
    check(start, x >= 0, "start");
    if (x >= 0) begin
      check(vec, x[7:0], "vector");
      check(vaddr, 16'(x * 2), "vector address");
      check(busy, 1'b1, "entry busy");
    end
    k = 0;
    while (busy !== 1'b0 && k < 20) begin
      @(posedge clk);
      #1 k++;
    end
    check(busy, 1'b0, "entry end");
    @(posedge clk);
    #1;
  endtask
  task automatic wrap_up();
    $display("checks %0d errors %0d", n_checks, num_errors);
    if (num_errors == 0 && n_checks > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask
  initial begin
    #100000;
    num_errors++;
    wrap_up();
  end
  // ----------------------------------------
  // scenarios
  // ----------------------------------------
  initial begin
    repeat (6) @(posedge clk);
    #1 rst_n = 1'b1;
    repeat (3) begin
      @(posedge clk);
      #1 check({chip_rst, start}, 2'b10, "start while pin low");
    end
    ext_n = 1'b1;
    fire(0);
    check(imask, 1'b1, "mask after reset");
    for (int n = 0; n < 4; n++) begin
      tn = n[1:0]; trap = 1; nmi = 1; bnd = 1;
      fire(8 + n);
    end
    irq = 26'h3FFFFFF; bnd = 1;
    fire(-1);
    irq = 26'h1; brk = 1; bnd = 1;
    fire(12);
    brk = 1; nmi = 1; bnd = 1;
    fire(7);
    repeat (8) begin
      lfsr = {lfsr[14:0], lfsr[15] ^ lfsr[13] ^ lfsr[12] ^ lfsr[10]};
      lat = {1'b0, lfsr[1:0]}; mclr = 1;
      @(posedge clk);
      #1 mclr = 0; irq = {lfsr[9:0], lfsr};
      check(imask, 1'b0, "mask cleared");
      @(posedge clk);
      #1 check(start, 1'b0, "no boundary");
      e = ref_vec(0, 0, 0, 0, irq, 0); bnd = 1;
      fire(e);
      check(imask, e >= 0, "mask after entry");
    end
    mset = 1;
    @(posedge clk);
    #1 mset = 0; en = 0; mclr = 1;
    check(imask, 1'b1, "mask set by software");
    @(posedge clk);
    #1 check(imask, 1'b1, "mask frozen while disabled");
    en = 1;
    mclr = 1;
    @(posedge clk);
    #1 mclr = 0; trap = 1; tn = 3; wdt = 1;
    @(posedge clk);
    #1 trap = 0; wdt = 0;
    check({chip_rst, start}, 2'b10, "watchdog reset");
    fire(0);
    check(imask, 1'b1, "mask after watchdog");
    wrap_up();
  end
endmodule // eec_exception_entry_control_tb_top
